// ### common/fsre_consts.svh
// constants for the flash self read / erase / unlock controller and its core-side sequencer
// How it works
// [RULE_01] software loads address, clears config select, sets read
// [RULE_02] second slot after read start is taken
// [RULE_03] fetched word lands in data pair next cycle
// [RULE_04] data pair holds word until read or write
// [RULE_05] software places two idle instructions after read
// [RULE_06] writes and erases need a full unlock sequence
// [RULE_07] unlock: 55h, AAh, write start, two idles
// [RULE_08] write start always forces two idle slots
// [RULE_09] erase or program stalls core for op time
// [RULE_10] latch load: two idle slots, no stall
// [RULE_11] software keeps interrupts off during unlock sequence
// [RULE_12] erase acts on the whole addressed row
// [RULE_13] erase: address, select, enable, keys, write start
// [RULE_14] two setup slots precede the erase halt
// [RULE_15] halt keeps clocks running, not a sleep
// [RULE_16] resume at third instruction after write start
// [RULE_17] start bits set by software, cleared by hardware
// [RULE_18] key register is write only, reads zero
// [RULE_19] reset during write or erase sets error flag
// [RULE_20] data word 14 bits, address 15 bits
// [RULE_21] keys must be back to back before start
// [RULE_22] bad start does nothing to flash contents
`ifndef FSRE_CONSTS_SVH
`define FSRE_CONSTS_SVH

// special function register offsets on the core side
`define FSRE_REG_ADDR_LOW 3'h0
`define FSRE_REG_ADDR_HIGH 3'h1
`define FSRE_REG_DATA_LOW 3'h2
`define FSRE_REG_DATA_HIGH 3'h3
`define FSRE_REG_CTRL 3'h4
`define FSRE_REG_KEY 3'h5

// flash_ctrl bit positions
`define FSRE_CTRL_RD 0
`define FSRE_CTRL_WR 1
`define FSRE_CTRL_WRITE_ENABLE 2
`define FSRE_CTRL_WRITE_ERROR_FLAG 3
`define FSRE_CTRL_FREE 4
`define FSRE_CTRL_LWLO 5
`define FSRE_CTRL_CONFIG_SPACE_SELECT 6

// flash_ctrl values used by the sequencer
`define FSRE_CV_READ 8'h01
`define FSRE_CV_ERASE_SET 8'h14
`define FSRE_CV_ERASE_GO 8'h16
`define FSRE_CV_LOAD_SET 8'h24
`define FSRE_CV_LOAD_GO 8'h26
`define FSRE_CV_PROG_SET 8'h04
`define FSRE_CV_PROG_GO 8'h06
`define FSRE_CV_OFF 8'h00

// unlock keys
`define FSRE_KEY1 8'h55
`define FSRE_KEY2 8'haa

// word geometry
`define FSRE_BLANK 14'h3fff
`define FSRE_ROW_WORDS 20'd32

// erase / program time
`define FSRE_OP_TIME_US 2000
`define FSRE_CLK_MHZ 250
`define FSRE_OP_CYC (`FSRE_OP_TIME_US * `FSRE_CLK_MHZ)

// sequencer user register offsets
`define FSRE_HREG_ADDR 2'h0
`define FSRE_HREG_DATA 2'h1
`define FSRE_HREG_CMD 2'h2
`define FSRE_HREG_STAT 2'h3

`endif

// ### common/fsre_pkg.sv
// types shared by the flash controller and the core-side sequencer
package fsre_pkg;
  // flash controller states
  typedef enum logic [2:0] {
    FSRE_DEV_IDLE = 3'b000,
    FSRE_DEV_RD1 = 3'b001,
    FSRE_DEV_RD2 = 3'b010,
    FSRE_DEV_WS1 = 3'b011,
    FSRE_DEV_WS2 = 3'b100,
    FSRE_DEV_BUSY = 3'b101
  } fsre_dev_state_t;
  // unlock tracker states
  typedef enum logic [1:0] {
    FSRE_UNL_NONE = 2'b00,
    FSRE_UNL_55 = 2'b01,
    FSRE_UNL_AA = 2'b10
  } fsre_unl_t;
  // sequencer commands
  typedef enum logic [2:0] {
    FSRE_OP_NONE = 3'b000,
    FSRE_OP_READ = 3'b001,
    FSRE_OP_ERASE = 3'b010,
    FSRE_OP_LOAD = 3'b011,
    FSRE_OP_PROG = 3'b100
  } fsre_op_t;
  // sequencer states
  typedef enum logic [0:0] {
    FSRE_H_IDLE = 1'b0,
    FSRE_H_RUN = 1'b1
  } fsre_hstate_t;
  // kind of one instruction slot
  typedef enum logic [1:0] {
    FSRE_ACC_NOP = 2'b00,
    FSRE_ACC_WR = 2'b01,
    FSRE_ACC_RD = 2'b10
  } fsre_acc_t;
  // one instruction of a sequence
  typedef struct packed {
    fsre_acc_t kind;
    logic [2:0] sel;
    logic [7:0] val;
    logic last;
  } fsre_instr_t;
endpackage

// ### common/fsre_if.sv
// core-to-flash-controller register and execution control link
`timescale 1ns/1ps
interface fsre_if;
  logic [2:0] sfr_addr; // register offset
  logic [7:0] sfr_wdata; // write data
  logic sfr_we; // write strobe
  logic sfr_re; // read strobe
  logic [7:0] sfr_rdata; // read data, cycle after read
  logic slot_squash; // this instruction slot is forced idle
  logic exec_stall; // instruction execution halted
  // core side
  modport core (
    output sfr_addr, sfr_wdata, sfr_we, sfr_re,
    input sfr_rdata, slot_squash, exec_stall
  );
  // flash controller side
  modport flash (
    input sfr_addr, sfr_wdata, sfr_we, sfr_re,
    output sfr_rdata, slot_squash, exec_stall
  );
endinterface

// ### logic/fsre_flash_ctrl.sv
// flash controller: read, row erase, latch load, row program with unlock guard
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "fsre_consts.svh"
module fsre_flash_ctrl #(
  parameter int unsigned OP_CYC = `FSRE_OP_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic por_n_i,
  fsre_if.flash bus,
  output logic busy_o,
  output logic write_error_o
);
  localparam logic [19:0] OP_LAST = 20'(OP_CYC - 1); // last stall cycle

  fsre_pkg::fsre_dev_state_t state_q, state_d; // flash controller state
  fsre_pkg::fsre_unl_t unlock_q; // key tracker
  logic [14:0] addr_q; // address pair
  logic [13:0] data_q; // data pair
  logic rd_q, wr_q, write_enable_q, free_q, lwlo_q, config_space_select_q; // control bits
  logic err_q; // write error flag
  logic wr_active_q; // long operation in progress
  logic squash_q, stall_q, busy_q; // execution control
  logic [7:0] rdata_q; // read return
  logic [19:0] cnt_q; // stall counter
  logic [13:0] latch_q [0:31]; // write latches
  logic [13:0] mem_q [0:32767]; // program flash array
  logic acc_we, acc_re, ctrl_wr, rd_go, ws_go, op_done;

  // accesses in forced-idle or stalled slots are not executed
  always_comb begin
    acc_we = bus.sfr_we && !squash_q && !stall_q;
    acc_re = bus.sfr_re && !squash_q && !stall_q;
    ctrl_wr = acc_we && (bus.sfr_addr == `FSRE_REG_CTRL);
    rd_go = ctrl_wr && bus.sfr_wdata[`FSRE_CTRL_RD] && (state_q == fsre_pkg::FSRE_DEV_IDLE); // RULE_01
    // start only after back-to-back keys, with writes enabled
    ws_go = ctrl_wr && bus.sfr_wdata[`FSRE_CTRL_WR] && (unlock_q == fsre_pkg::FSRE_UNL_AA) // RULE_06
      && bus.sfr_wdata[`FSRE_CTRL_WRITE_ENABLE] && !bus.sfr_wdata[`FSRE_CTRL_CONFIG_SPACE_SELECT] // RULE_22
      && (state_q == fsre_pkg::FSRE_DEV_IDLE);
    op_done = (state_q == fsre_pkg::FSRE_DEV_BUSY) && (cnt_q == OP_LAST);
  end

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      fsre_pkg::FSRE_DEV_IDLE: begin
        if (ws_go) begin
          state_d = fsre_pkg::FSRE_DEV_WS1; // write start wins over read start
        end else if (rd_go) begin
          state_d = fsre_pkg::FSRE_DEV_RD1;
        end
      end
      fsre_pkg::FSRE_DEV_RD1: state_d = fsre_pkg::FSRE_DEV_RD2; // first follower runs
      fsre_pkg::FSRE_DEV_RD2: state_d = fsre_pkg::FSRE_DEV_IDLE; // fetch slot
      fsre_pkg::FSRE_DEV_WS1: state_d = fsre_pkg::FSRE_DEV_WS2;
      fsre_pkg::FSRE_DEV_WS2: begin
        state_d = lwlo_q ? fsre_pkg::FSRE_DEV_IDLE : fsre_pkg::FSRE_DEV_BUSY; // RULE_10
      end
      fsre_pkg::FSRE_DEV_BUSY: begin
        if (op_done) begin
          state_d = fsre_pkg::FSRE_DEV_IDLE; // RULE_16
        end
      end
      default: state_d = fsre_pkg::FSRE_DEV_IDLE;
    endcase
  end

  // state register and execution control outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= fsre_pkg::FSRE_DEV_IDLE;
      squash_q <= 1'b0;
      stall_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // two forced idles after write start, fetch slot after read start
      squash_q <= (state_d == fsre_pkg::FSRE_DEV_WS1) || (state_d == fsre_pkg::FSRE_DEV_WS2) // RULE_08 RULE_14
        || (state_d == fsre_pkg::FSRE_DEV_RD2); // RULE_02
      // core halts but clocks and peripherals keep running
      stall_q <= (state_d == fsre_pkg::FSRE_DEV_BUSY); // RULE_09 RULE_15
      busy_q <= (state_d != fsre_pkg::FSRE_DEV_IDLE);
    end
  end

  // stall duration counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 20'h00000;
    end else if (state_q == fsre_pkg::FSRE_DEV_BUSY) begin
      cnt_q <= cnt_q + 20'h00001; // RULE_09
    end else begin
      cnt_q <= 20'h00000;
    end
  end

  // unlock tracker, any other executed access breaks the chain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unlock_q <= fsre_pkg::FSRE_UNL_NONE;
    end else if (acc_we || acc_re) begin
      if (acc_we && bus.sfr_addr == `FSRE_REG_KEY && bus.sfr_wdata == `FSRE_KEY1) begin
        unlock_q <= fsre_pkg::FSRE_UNL_55; // RULE_21
      end else if (acc_we && bus.sfr_addr == `FSRE_REG_KEY && bus.sfr_wdata == `FSRE_KEY2
                   && unlock_q == fsre_pkg::FSRE_UNL_55) begin
        unlock_q <= fsre_pkg::FSRE_UNL_AA; // RULE_21
      end else begin
        unlock_q <= fsre_pkg::FSRE_UNL_NONE; // RULE_21
      end
    end
  end

  // control bits; start bits are set only, cleared on completion
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      write_enable_q <= 1'b0;
      free_q <= 1'b0;
      lwlo_q <= 1'b0;
      config_space_select_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        write_enable_q <= bus.sfr_wdata[`FSRE_CTRL_WRITE_ENABLE];
        free_q <= bus.sfr_wdata[`FSRE_CTRL_FREE];
        lwlo_q <= bus.sfr_wdata[`FSRE_CTRL_LWLO];
        config_space_select_q <= bus.sfr_wdata[`FSRE_CTRL_CONFIG_SPACE_SELECT];
      end
      if (rd_go && !ws_go) begin
        rd_q <= 1'b1;
      end else if (state_q == fsre_pkg::FSRE_DEV_RD2) begin
        rd_q <= 1'b0; // RULE_17
      end
      if (ws_go) begin
        wr_q <= 1'b1;
      end else if ((state_q == fsre_pkg::FSRE_DEV_WS2 && lwlo_q) || op_done) begin
        wr_q <= 1'b0; // RULE_17
      end
    end
  end

  // address pair, high part 7 bits
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= 15'h0000;
    end else if (acc_we && bus.sfr_addr == `FSRE_REG_ADDR_LOW) begin
      addr_q[7:0] <= bus.sfr_wdata; // RULE_20
    end else if (acc_we && bus.sfr_addr == `FSRE_REG_ADDR_HIGH) begin
      addr_q[14:8] <= bus.sfr_wdata[6:0]; // RULE_20
    end
  end

  // data pair: fetch loads it, software writes overwrite it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_q <= 14'h0000;
    end else if (state_q == fsre_pkg::FSRE_DEV_RD2) begin
      data_q <= config_space_select_q ? 14'h0000 : mem_q[addr_q]; // RULE_03
    end else if (acc_we && bus.sfr_addr == `FSRE_REG_DATA_LOW) begin
      data_q[7:0] <= bus.sfr_wdata; // RULE_04
    end else if (acc_we && bus.sfr_addr == `FSRE_REG_DATA_HIGH) begin
      data_q[13:8] <= bus.sfr_wdata[5:0]; // RULE_04
    end
  end

  // write latches, blanked after every erase or program
  for (genvar i = 0; i < 32; i++) begin : g_latch
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        latch_q[i] <= `FSRE_BLANK;
      end else if (op_done) begin
        latch_q[i] <= `FSRE_BLANK;
      end else if (state_q == fsre_pkg::FSRE_DEV_WS2 && lwlo_q && addr_q[4:0] == 5'(i)) begin
        latch_q[i] <= data_q; // RULE_10
      end
    end
  end

  // array update: one word per stall cycle over the addressed row
  always_ff @(posedge clk_i) begin
    if (state_q == fsre_pkg::FSRE_DEV_BUSY && cnt_q < `FSRE_ROW_WORDS) begin
      if (free_q) begin
        mem_q[{addr_q[14:5], cnt_q[4:0]}] <= `FSRE_BLANK; // RULE_12
      end else begin
        // programming only clears bits, blank latches leave words alone
        mem_q[{addr_q[14:5], cnt_q[4:0]}] <= mem_q[{addr_q[14:5], cnt_q[4:0]}] & latch_q[cnt_q[4:0]];
      end
    end
  end

  // read return one cycle after an executed read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (acc_re) begin
      case (bus.sfr_addr)
        `FSRE_REG_ADDR_LOW: rdata_q <= addr_q[7:0];
        `FSRE_REG_ADDR_HIGH: rdata_q <= {1'b0, addr_q[14:8]};
        `FSRE_REG_DATA_LOW: rdata_q <= data_q[7:0];
        `FSRE_REG_DATA_HIGH: rdata_q <= {2'b00, data_q[13:8]};
        `FSRE_REG_CTRL: rdata_q <= {1'b0, config_space_select_q, lwlo_q, free_q, err_q, write_enable_q, wr_q, rd_q};
        `FSRE_REG_KEY: rdata_q <= 8'h00; // RULE_18
        default: rdata_q <= 8'h00; // unmapped
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // long-operation marker, not cleared until the first clock edge in core reset, so the error can be seen
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      wr_active_q <= 1'b0;
    end else if (!arst_n_i) begin
      wr_active_q <= 1'b0;
    end else if (state_q == fsre_pkg::FSRE_DEV_WS2 && !lwlo_q) begin
      wr_active_q <= 1'b1;
    end else if (op_done) begin
      wr_active_q <= 1'b0;
    end
  end

  // error flag: set by interrupted operation, cleared by writing zero
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      err_q <= 1'b0;
    end else if (!arst_n_i && wr_active_q) begin
      err_q <= 1'b1; // RULE_19
    end else if (ctrl_wr && !bus.sfr_wdata[`FSRE_CTRL_WRITE_ERROR_FLAG]) begin
      err_q <= 1'b0;
    end
  end

  // user side outputs
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      write_error_o <= 1'b0;
    end else begin
      write_error_o <= err_q;
    end
  end

  assign busy_o = busy_q;
  assign bus.slot_squash = squash_q;
  assign bus.exec_stall = stall_q;
  assign bus.sfr_rdata = rdata_q;
endmodule

// ### logic/fsre_cpu_seq.sv
// core-side sequencer: runs read, erase, latch load and program instruction sequences
`timescale 1ns/1ps
`include "fsre_consts.svh"
module fsre_cpu_seq (
  input wire logic clk_i,
  input wire logic arst_n_i,
  fsre_if.core bus,
  input wire logic [1:0] usr_addr_i,
  input wire logic [15:0] usr_wdata_i,
  input wire logic usr_we_i,
  input wire logic usr_re_i,
  output logic [15:0] usr_rdata_o
);
  fsre_pkg::fsre_hstate_t state_q; // run state
  fsre_pkg::fsre_op_t op_q; // running command
  logic [3:0] step_q; // instruction index
  logic [14:0] cmd_addr_q; // target address
  logic [13:0] cmd_data_q; // word to load
  logic [13:0] rd_word_q; // last word read
  logic [1:0] pend_q; // read return pending, bit1 high byte
  logic [2:0] addr_q; // bus outputs
  logic [7:0] wdata_q;
  logic we_q, re_q;
  logic [15:0] rdata_q;
  fsre_pkg::fsre_instr_t cur, nxt, first;
  logic start;

  // one instruction of the sequence for a command and step
  function automatic fsre_pkg::fsre_instr_t instr(fsre_pkg::fsre_op_t op, logic [3:0] st,
                                                  logic [14:0] a, logic [13:0] d);
    fsre_pkg::fsre_instr_t r;
    logic [7:0] set_v, go_v;
    r = '{fsre_pkg::FSRE_ACC_NOP, 3'h0, 8'h00, 1'b0};
    set_v = (op == fsre_pkg::FSRE_OP_LOAD) ? `FSRE_CV_LOAD_SET : `FSRE_CV_PROG_SET;
    go_v = (op == fsre_pkg::FSRE_OP_LOAD) ? `FSRE_CV_LOAD_GO : `FSRE_CV_PROG_GO;
    case (op)
      fsre_pkg::FSRE_OP_READ: begin
        case (st)
          4'h0: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_ADDR_LOW, a[7:0], 1'b0}; // RULE_01
          4'h1: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_ADDR_HIGH, {1'b0, a[14:8]}, 1'b0};
          4'h2: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, `FSRE_CV_READ, 1'b0}; // RULE_01
          4'h5: r = '{fsre_pkg::FSRE_ACC_RD, `FSRE_REG_DATA_LOW, 8'h00, 1'b0};
          4'h6: r = '{fsre_pkg::FSRE_ACC_RD, `FSRE_REG_DATA_HIGH, 8'h00, 1'b1};
          default: r = '{fsre_pkg::FSRE_ACC_NOP, 3'h0, 8'h00, 1'b0}; // RULE_05
        endcase
      end
      fsre_pkg::FSRE_OP_ERASE: begin
        case (st)
          4'h0: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_ADDR_LOW, a[7:0], 1'b0}; // RULE_13
          4'h1: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_ADDR_HIGH, {1'b0, a[14:8]}, 1'b0};
          4'h2: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, `FSRE_CV_ERASE_SET, 1'b0}; // RULE_13
          4'h3: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_KEY, `FSRE_KEY1, 1'b0}; // RULE_07
          4'h4: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_KEY, `FSRE_KEY2, 1'b0}; // RULE_07
          4'h5: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, `FSRE_CV_ERASE_GO, 1'b0}; // RULE_07
          4'h8: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, `FSRE_CV_OFF, 1'b1};
          default: r = '{fsre_pkg::FSRE_ACC_NOP, 3'h0, 8'h00, 1'b0};
        endcase
      end
      fsre_pkg::FSRE_OP_LOAD, fsre_pkg::FSRE_OP_PROG: begin
        case (st)
          4'h0: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_ADDR_LOW, a[7:0], 1'b0};
          4'h1: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_ADDR_HIGH, {1'b0, a[14:8]}, 1'b0};
          4'h2: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_DATA_LOW, d[7:0], 1'b0};
          4'h3: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_DATA_HIGH, {2'b00, d[13:8]}, 1'b0};
          4'h4: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, set_v, 1'b0};
          4'h5: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_KEY, `FSRE_KEY1, 1'b0}; // RULE_07
          4'h6: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_KEY, `FSRE_KEY2, 1'b0}; // RULE_07
          4'h7: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, go_v, 1'b0}; // RULE_07
          4'ha: r = '{fsre_pkg::FSRE_ACC_WR, `FSRE_REG_CTRL, `FSRE_CV_OFF, 1'b1};
          default: r = '{fsre_pkg::FSRE_ACC_NOP, 3'h0, 8'h00, 1'b0};
        endcase
      end
      default: r = '{fsre_pkg::FSRE_ACC_NOP, 3'h0, 8'h00, 1'b1};
    endcase
    return r;
  endfunction

  // current, next and first instruction
  always_comb begin
    cur = instr(op_q, step_q, cmd_addr_q, cmd_data_q);
    nxt = instr(op_q, step_q + 4'h1, cmd_addr_q, cmd_data_q);
    first = instr(fsre_pkg::fsre_op_t'(usr_wdata_i[2:0]), 4'h0, cmd_addr_q, cmd_data_q);
    start = usr_we_i && usr_addr_i == `FSRE_HREG_CMD && state_q == fsre_pkg::FSRE_H_IDLE
      && pend_q == 2'b00 && usr_wdata_i[2:0] != 3'b000 && usr_wdata_i[2:0] <= 3'b100;
  end

  // sequence engine, holds its instruction while the flash stalls the core
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= fsre_pkg::FSRE_H_IDLE;
      op_q <= fsre_pkg::FSRE_OP_NONE;
      step_q <= 4'h0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      re_q <= 1'b0;
    end else if (state_q == fsre_pkg::FSRE_H_IDLE) begin
      if (start) begin
        state_q <= fsre_pkg::FSRE_H_RUN; // interrupts are not taken while running
        op_q <= fsre_pkg::fsre_op_t'(usr_wdata_i[2:0]);
        step_q <= 4'h0;
        addr_q <= first.sel;
        wdata_q <= first.val;
        we_q <= (first.kind == fsre_pkg::FSRE_ACC_WR);
        re_q <= (first.kind == fsre_pkg::FSRE_ACC_RD);
      end
    end else if (!bus.exec_stall) begin
      if (cur.last) begin
        state_q <= fsre_pkg::FSRE_H_IDLE; // RULE_11
        we_q <= 1'b0;
        re_q <= 1'b0;
      end else begin
        step_q <= step_q + 4'h1; // RULE_16
        addr_q <= nxt.sel;
        wdata_q <= nxt.val;
        we_q <= (nxt.kind == fsre_pkg::FSRE_ACC_WR);
        re_q <= (nxt.kind == fsre_pkg::FSRE_ACC_RD);
      end
    end
  end

  // read returns pair into one word, low byte first
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= 2'b00;
      rd_word_q <= 14'h0000;
    end else begin
      pend_q[0] <= re_q && !bus.exec_stall && !bus.slot_squash && addr_q == `FSRE_REG_DATA_LOW;
      pend_q[1] <= re_q && !bus.exec_stall && !bus.slot_squash && addr_q == `FSRE_REG_DATA_HIGH;
      if (pend_q[0]) begin
        rd_word_q[7:0] <= bus.sfr_rdata;
      end
      if (pend_q[1]) begin
        rd_word_q[13:8] <= bus.sfr_rdata[5:0];
      end
    end
  end

  // user command registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_addr_q <= 15'h0000;
      cmd_data_q <= 14'h0000;
    end else if (usr_we_i && state_q == fsre_pkg::FSRE_H_IDLE) begin
      if (usr_addr_i == `FSRE_HREG_ADDR) begin
        cmd_addr_q <= usr_wdata_i[14:0];
      end
      if (usr_addr_i == `FSRE_HREG_DATA) begin
        cmd_data_q <= usr_wdata_i[13:0];
      end
    end
  end

  // user read data, one cycle after the read strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 16'h0000;
    end else if (usr_re_i) begin
      case (usr_addr_i)
        `FSRE_HREG_ADDR: rdata_q <= {1'b0, cmd_addr_q};
        `FSRE_HREG_DATA: rdata_q <= {2'b00, rd_word_q};
        `FSRE_HREG_CMD: rdata_q <= {13'h0000, op_q};
        default: rdata_q <= {15'h0000, (state_q == fsre_pkg::FSRE_H_RUN) || (pend_q != 2'b00)};
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign usr_rdata_o = rdata_q;
  assign bus.sfr_addr = addr_q;
  assign bus.sfr_wdata = wdata_q;
  assign bus.sfr_we = we_q;
  assign bus.sfr_re = re_q;
endmodule

// ### test/fsre_monitor.sv
// checker on the core-to-flash link
`timescale 1ns/1ps
`include "fsre_consts.svh"
module fsre_monitor #(
  parameter int unsigned OP_CYC = 40
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_rdata,
  input wire logic slot_squash,
  input wire logic exec_stall
);
  logic live; // access really executes
  logic [31:0] stall_cnt_q; // cycles held so far
  assign live = !slot_squash && !exec_stall;
  // count the length of each stall
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stall_cnt_q <= 32'h0;
    end else begin
      stall_cnt_q <= exec_stall ? stall_cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence key_a;
    sfr_we && live && sfr_addr == `FSRE_REG_KEY && sfr_wdata == `FSRE_KEY1;
  endsequence
  sequence key_b;
    sfr_we && live && sfr_addr == `FSRE_REG_KEY && sfr_wdata == `FSRE_KEY2;
  endsequence
  sequence ctl(logic [7:0] v);
    sfr_we && live && sfr_addr == `FSRE_REG_CTRL && sfr_wdata == v;
  endsequence
  sequence go_start;
    key_a ##1 key_b ##1 (sfr_we && live && sfr_addr == `FSRE_REG_CTRL && sfr_wdata[1]);
  endsequence
  a_read_slot_taken: assert property (ctl(`FSRE_CV_READ) |=> !slot_squash ##1 slot_squash ##1 !slot_squash)
    else $error("read did not take the second slot");
  a_start_two_idle: assert property (go_start |=> slot_squash [*2] ##1 !slot_squash)
    else $error("write start gave no two idle slots");
  a_erase_halts: assert property (key_a ##1 key_b ##1 ctl(`FSRE_CV_ERASE_GO) |=> ##2 exec_stall)
    else $error("erase did not halt after setup");
  a_program_halts: assert property (key_a ##1 key_b ##1 ctl(`FSRE_CV_PROG_GO) |=> ##2 exec_stall)
    else $error("program did not halt");
  a_load_no_stall: assert property (key_a ##1 key_b ##1 ctl(`FSRE_CV_LOAD_GO) |=> !exec_stall [*4])
    else $error("latch load stalled");
  a_stall_length: assert property ($fell(exec_stall) |-> stall_cnt_q == OP_CYC)
    else $error("stall length wrong");
  a_setup_before_halt: assert property ($rose(exec_stall) |-> $past(slot_squash) && $past(slot_squash, 2))
    else $error("halt without two setup slots");
  a_resume_executes: assert property ($fell(exec_stall) |-> !slot_squash)
    else $error("slot lost on resume");
  a_rdata_quiet: assert property (!$past(sfr_re) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
endmodule

// ### test/flash_self_read_erase_unlock_test.sv
// bench: sequencer and flash controller joined by the link
`timescale 1ns/1ps
`include "fsre_consts.svh"
module flash_self_read_erase_unlock_test;
  localparam int unsigned OPC = 40; // short stall
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic por_n_i = 1'b0;
  logic [1:0] usr_addr_i = 2'h0;
  logic [15:0] usr_wdata_i = 16'h0000;
  logic usr_we_i = 1'b0;
  logic usr_re_i = 1'b0;
  logic [15:0] usr_rdata_o;
  logic write_error_o;
  logic busy_o; // flash controller not idle
  logic chk_q = 1'b0; // a data answer stands now
  logic [15:0] exp_q[$]; // expected words
  logic [14:0] row; // random row base
  logic [15:0] wd; // random word
  int error_cnt = 0;
  int samples_checked = 0;
  fsre_if link();
  always #2 clk_i = ~clk_i;
  fsre_flash_ctrl #(.OP_CYC(OPC)) u_fsre_flash_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .por_n_i(por_n_i), .bus(link.flash), .busy_o(busy_o), .write_error_o(write_error_o));
  fsre_cpu_seq u_fsre_cpu_seq (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(link.core),
    .usr_addr_i(usr_addr_i), .usr_wdata_i(usr_wdata_i), .usr_we_i(usr_we_i),
    .usr_re_i(usr_re_i), .usr_rdata_o(usr_rdata_o));
  fsre_monitor #(.OP_CYC(OPC)) u_fsre_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata), .sfr_we(link.sfr_we),
    .sfr_re(link.sfr_re), .sfr_rdata(link.sfr_rdata), .slot_squash(link.slot_squash),
    .exec_stall(link.exec_stall));
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // single-bit status compare
  task cmp_flag(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task end_sim;
    $display("compared %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    usr_addr_i <= a;
    usr_wdata_i <= d;
    usr_we_i <= 1'b1;
    @(posedge clk_i);
    usr_we_i <= 1'b0;
  endtask
  task rd(input logic [1:0] a);
    @(posedge clk_i);
    usr_addr_i <= a;
    usr_re_i <= 1'b1;
    @(posedge clk_i);
    usr_re_i <= 1'b0;
  endtask
  // command, then poll busy under a bound
  task run(input logic [15:0] c);
    int n;
    wr(`FSRE_HREG_CMD, c);
    n = 0;
    do begin
      rd(`FSRE_HREG_STAT);
      #1;
      n++;
    end while (usr_rdata_o[0] !== 1'b0 && n < 300);
    if (usr_rdata_o[0] !== 1'b0) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task rdq(input logic [15:0] e);
    exp_q.push_back(e);
    rd(`FSRE_HREG_DATA);
  endtask
  // answer watcher
  always @(posedge clk_i) chk_q <= usr_re_i && usr_addr_i == `FSRE_HREG_DATA;
  always @(negedge clk_i) begin
    if (chk_q) begin
      cmp("word", exp_q.pop_front(), usr_rdata_o);
    end
  end
  initial begin
    void'($urandom(21));
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    row = 15'($urandom) & 15'h7fe0;
    wd = 16'($urandom) & 16'h3fff;
    wr(`FSRE_HREG_ADDR, {1'b0, row | 15'h0013});
    run(16'h0002);
    wr(`FSRE_HREG_ADDR, {1'b0, row | 15'h0005});
    run(16'h0001);
    rdq(16'h3fff);
    wr(`FSRE_HREG_DATA, wd);
    run(16'h0003);
    run(16'h0004);
    run(16'h0001);
    rdq(wd);
    rdq(wd);
    wr(`FSRE_HREG_ADDR, {1'b0, row | 15'h0006});
    run(16'h0001);
    rdq(16'h3fff);
    // core reset in mid-erase
    wr(`FSRE_HREG_CMD, 16'h0002);
    repeat (19) @(posedge clk_i);
    #1;
    cmp_flag("busy", 1'b1, busy_o);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    cmp_flag("write_error", 1'b1, write_error_o);
    cmp_flag("busy", 1'b0, busy_o);
    repeat (2) @(posedge clk_i);
    end_sim();
  end
endmodule
